// file: src/sleep_status_pkg.sv
// Constants and carrier types for the sleep and status command block
package sleep_status_pkg;

   // ----------------------------------------------------------------
   // Command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_SLEEP_ENTRY = 8'h10;
   localparam logic [7:0] CMD_SLEEP_EXIT = 8'h11;
   localparam logic [7:0] CMD_READ_SIGNAL_STATUS = 8'h0E;
   localparam logic [7:0] CMD_READ_SELF_DIAG = 8'h0F;

   // ----------------------------------------------------------------
   // Read byte layout and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam int SIG_TE_ON_BIT = 7;
   localparam int SIG_TE_MODE_BIT = 6;
   localparam int SIG_LINK_ERR_BIT = 0;
   localparam int DIAG_LOAD_BIT = 7;
   localparam int DIAG_FUNC_BIT = 6;
   localparam int DIAG_CSUM_BIT = 0;
   localparam int ZERO_FIELD_HI = 5;
   localparam int ZERO_FIELD_LO = 1;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int SYS_CLK_MHZ = 50;
   localparam int SETTLE_TIME_US = 5000;
   localparam int SETTLE_CYCLES = SETTLE_TIME_US * SYS_CLK_MHZ;
   localparam int MAX_ENTRY_TIME_US = 120000;
   localparam int MAX_ENTRY_CYCLES = MAX_ENTRY_TIME_US * SYS_CLK_MHZ;
   localparam int HOST_CSUM_WAIT_MS = 300;
   localparam int WAKE_HOLD_TIME_US = 120000;
   localparam int TIMER_W = 24;
   localparam logic [TIMER_W-1:0] TIMER_ZERO = 24'h000000;
   localparam logic [TIMER_W-1:0] TIMER_ONE = 24'h000001;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      ST_ASLEEP = 2'b00,
      ST_WAKING = 2'b01,
      ST_AWAKE = 2'b10,
      ST_ENTERING = 2'b11
   } power_state_type;

   typedef struct packed
   {
      logic te_on;
      logic te_mode;
      logic link_err;
   } signal_status_type;

   typedef struct packed
   {
      logic regs_match;
      logic func_pass;
      logic csum_differ;
   } diag_check_type;

   typedef struct packed
   {
      logic dcdc_en;
      logic osc_en;
      logic scan_en;
      logic backlight_en;
      logic display_en;
      logic als_en;
      logic dimming_en;
   } power_ctl_type;

endpackage

// file: src/sleep_status_ctl.sv
// Sleep entry/exit sequencing and status read commands over a link clock
`timescale 1ns/1ns
`default_nettype none

module sleep_status_ctl #(
   parameter int SETTLE_CYCLES = sleep_status_pkg::SETTLE_CYCLES
)(
   // System clock domain
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic soft_reset,
   // Link clock domain
   input wire logic link_clk,
   input wire logic link_nrst,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic link_busy,
   // Device status sources
   input wire sleep_status_pkg::signal_status_type sig_status,
   input wire sleep_status_pkg::diag_check_type diag_check,
   input wire logic als_request,
   input wire logic dimming_request,
   // Power control
   output sleep_status_pkg::power_ctl_type power_ctl,
   output logic asleep
);

   // ----------------------------------------------------------------
   // Link side: command capture and answer
   // ----------------------------------------------------------------
   logic [7:0] cmd_hold;
   logic req_tgl;
   logic ack_s1;
   logic ack_s2;
   logic ack_seen;
   logic [7:0] rsp_hold;
   logic ack_tgl;
   logic hold_is_read;

   assign hold_is_read = (cmd_hold == sleep_status_pkg::CMD_READ_SIGNAL_STATUS)
      || (cmd_hold == sleep_status_pkg::CMD_READ_SELF_DIAG);

   always_ff @(posedge link_clk)
   begin
      if (!link_nrst)
      begin
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
      end
      else
      begin
         ack_s1 <= ack_tgl;
         ack_s2 <= ack_s1;
      end
   end

   // Command held stable until the system side acknowledges it
   always_ff @(posedge link_clk)
   begin
      if (!link_nrst)
      begin
         cmd_hold <= sleep_status_pkg::BYTE_RESET;
         req_tgl <= 1'b0;
         link_busy <= 1'b0;
         ack_seen <= 1'b0;
      end
      else if (cmd_valid && !link_busy)
      begin
         cmd_hold <= cmd_code;
         req_tgl <= ~req_tgl;
         link_busy <= 1'b1;
      end
      else if (ack_s2 != ack_seen)
      begin
         ack_seen <= ack_s2;
         link_busy <= 1'b0;
      end
   end

   // Answer byte is stable in rsp_hold once the ack toggle arrives
   always_ff @(posedge link_clk)
   begin
      if (!link_nrst)
      begin
         rsp_valid <= 1'b0;
         rsp_data <= sleep_status_pkg::BYTE_RESET;
      end
      else
      begin
         rsp_valid <= (ack_s2 != ack_seen) && hold_is_read;
         if ((ack_s2 != ack_seen) && hold_is_read)
         begin
            rsp_data <= rsp_hold;
         end
      end
   end

   // ----------------------------------------------------------------
   // System side: command decode
   // ----------------------------------------------------------------
   logic rst_any;
   logic req_s1;
   logic req_s2;
   logic req_seen;
   logic new_cmd;
   logic [7:0] diag_result;
   logic [7:0] sig_byte;
   sleep_status_pkg::power_state_type state;
   logic [sleep_status_pkg::TIMER_W-1:0] timer;
   logic timer_done;

   // Soft reset clears state, outputs and diagnostic result; the handshake resets on nrst and link_nrst only
   assign rst_any = !nrst || soft_reset;
   assign new_cmd = req_s2 != req_seen;
   assign timer_done = timer == sleep_status_pkg::TIMER_ZERO;

   always_comb
   begin
      sig_byte = sleep_status_pkg::BYTE_RESET;
      sig_byte[sleep_status_pkg::SIG_TE_ON_BIT] = sig_status.te_on;
      sig_byte[sleep_status_pkg::SIG_TE_MODE_BIT] = sig_status.te_mode;
      sig_byte[sleep_status_pkg::SIG_LINK_ERR_BIT] = sig_status.link_err;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
      end
      else
      begin
         req_s1 <= req_tgl;
         req_s2 <= req_s1;
      end
   end

   // Every command is acknowledged in every power state
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         req_seen <= 1'b0;
         ack_tgl <= 1'b0;
         rsp_hold <= sleep_status_pkg::BYTE_RESET;
      end
      else if (new_cmd)
      begin
         req_seen <= req_s2;
         ack_tgl <= ~ack_tgl;
         if (cmd_hold == sleep_status_pkg::CMD_READ_SELF_DIAG)
         begin
            rsp_hold <= diag_result;
         end
         else
         begin
            rsp_hold <= sig_byte;
         end
      end
   end

   // ----------------------------------------------------------------
   // Power sequencing
   // ----------------------------------------------------------------
   // Both transitions share one settle count; entry thus ends well
   // inside its upper bound.
   always_ff @(posedge sys_clk)
   begin
      if (rst_any)
      begin
         state <= sleep_status_pkg::ST_ASLEEP;
         timer <= sleep_status_pkg::TIMER_ZERO;
      end
      else
      begin
         if (!timer_done)
         begin
            timer <= timer - sleep_status_pkg::TIMER_ONE;
         end
         case (state)
            sleep_status_pkg::ST_ASLEEP:
            begin
               // Sleep entry here is ignored; only exit wakes
               if (new_cmd && cmd_hold == sleep_status_pkg::CMD_SLEEP_EXIT)
               begin
                  state <= sleep_status_pkg::ST_WAKING;
                  timer <= sleep_status_pkg::TIMER_W'(SETTLE_CYCLES - 1);
               end
            end
            sleep_status_pkg::ST_WAKING:
            begin
               if (timer_done)
               begin
                  state <= sleep_status_pkg::ST_AWAKE;
               end
            end
            sleep_status_pkg::ST_AWAKE:
            begin
               if (new_cmd && cmd_hold == sleep_status_pkg::CMD_SLEEP_ENTRY)
               begin
                  state <= sleep_status_pkg::ST_ENTERING;
                  timer <= sleep_status_pkg::TIMER_W'(SETTLE_CYCLES - 1);
               end
            end
            sleep_status_pkg::ST_ENTERING:
            begin
               if (timer_done)
               begin
                  state <= sleep_status_pkg::ST_ASLEEP;
               end
            end
            default:
            begin
               state <= sleep_status_pkg::ST_ASLEEP;
            end
         endcase
      end
   end

   // Scan and drive drop at once; supplies follow after the settle
   always_ff @(posedge sys_clk)
   begin
      if (rst_any)
      begin
         power_ctl <= '0;
         asleep <= 1'b1;
      end
      else
      begin
         asleep <= state == sleep_status_pkg::ST_ASLEEP;
         power_ctl.dcdc_en <= state != sleep_status_pkg::ST_ASLEEP;
         power_ctl.osc_en <= state != sleep_status_pkg::ST_ASLEEP;
         power_ctl.scan_en <= state == sleep_status_pkg::ST_AWAKE;
         power_ctl.backlight_en <= state == sleep_status_pkg::ST_AWAKE;
         power_ctl.display_en <= state == sleep_status_pkg::ST_AWAKE;
         power_ctl.als_en <= als_request
            && state == sleep_status_pkg::ST_AWAKE;
         power_ctl.dimming_en <= dimming_request
            && state == sleep_status_pkg::ST_AWAKE;
      end
   end

   // ----------------------------------------------------------------
   // Self-diagnostic result
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (rst_any)
      begin
         diag_result <= sleep_status_pkg::BYTE_RESET;
      end
      else if (state == sleep_status_pkg::ST_WAKING && timer_done)
      begin
         if (diag_check.regs_match)
         begin
            diag_result[sleep_status_pkg::DIAG_LOAD_BIT] <=
               ~diag_result[sleep_status_pkg::DIAG_LOAD_BIT];
         end
         if (diag_check.func_pass)
         begin
            diag_result[sleep_status_pkg::DIAG_FUNC_BIT] <=
               ~diag_result[sleep_status_pkg::DIAG_FUNC_BIT];
         end
         diag_result[sleep_status_pkg::DIAG_CSUM_BIT] <=
            diag_check.csum_differ;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   logic [sleep_status_pkg::TIMER_W-1:0] entry_age;

   always_ff @(posedge sys_clk)
   begin
      if (rst_any || state != sleep_status_pkg::ST_ENTERING)
      begin
         entry_age <= sleep_status_pkg::TIMER_ZERO;
      end
      else
      begin
         entry_age <= entry_age + sleep_status_pkg::TIMER_ONE;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst_any);

   sleep_outputs_off_a: assert property (
      asleep |-> !power_ctl.backlight_en && !power_ctl.display_en
         && !power_ctl.als_en)
      else $error("drive or light control on while asleep");
   sleep_power_off_a: assert property (
      asleep |-> !power_ctl.dcdc_en && !power_ctl.osc_en
         && !power_ctl.scan_en)
      else $error("supply or scan running while asleep");
   entry_no_dim_a: assert property (
      state == sleep_status_pkg::ST_ENTERING |=> !power_ctl.dimming_en)
      else $error("dimming active during sleep entry");
   entry_ignored_a: assert property (
      (state == sleep_status_pkg::ST_ASLEEP && new_cmd
         && cmd_hold == sleep_status_pkg::CMD_SLEEP_ENTRY)
      |=> state == sleep_status_pkg::ST_ASLEEP && $stable(diag_result))
      else $error("sleep entry while asleep changed state");
   only_exit_wakes_a: assert property (
      (state == sleep_status_pkg::ST_ASLEEP && !(new_cmd
         && cmd_hold == sleep_status_pkg::CMD_SLEEP_EXIT))
      |=> state == sleep_status_pkg::ST_ASLEEP)
      else $error("left sleep without exit command");
   entry_bound_a: assert property (
      entry_age < sleep_status_pkg::TIMER_W'(sleep_status_pkg::MAX_ENTRY_CYCLES))
      else $error("sleep entry took too long");
   wake_power_a: assert property (
      $rose(state == sleep_status_pkg::ST_WAKING)
      |=> power_ctl.dcdc_en && power_ctl.osc_en ##1 !asleep)
      else $error("supplies not restarted on wake");
   diag_zero_a: assert property (
      diag_result[sleep_status_pkg::ZERO_FIELD_HI:
         sleep_status_pkg::ZERO_FIELD_LO] == 5'h00)
      else $error("diagnostic reserved bits set");
   load_toggle_a: assert property (
      (state == sleep_status_pkg::ST_WAKING && timer_done
         && diag_check.regs_match)
      |=> diag_result[sleep_status_pkg::DIAG_LOAD_BIT]
         != $past(diag_result[sleep_status_pkg::DIAG_LOAD_BIT]))
      else $error("load bit did not toggle");
   func_toggle_a: assert property (
      (state == sleep_status_pkg::ST_WAKING && timer_done)
      |=> diag_result[sleep_status_pkg::DIAG_FUNC_BIT]
         == ($past(diag_result[sleep_status_pkg::DIAG_FUNC_BIT])
         ^ $past(diag_check.func_pass)))
      else $error("function bit wrong after wake");
   csum_report_a: assert property (
      (state == sleep_status_pkg::ST_WAKING && timer_done)
      |=> diag_result[sleep_status_pkg::DIAG_CSUM_BIT]
         == $past(diag_check.csum_differ))
      else $error("checksum bit wrong after wake");
   cmd_acked_a: assert property (
      new_cmd |=> ack_tgl != $past(ack_tgl))
      else $error("command not acknowledged");
   reset_asleep_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      soft_reset |=> asleep && state == sleep_status_pkg::ST_ASLEEP)
      else $error("not asleep after software reset");
   sig_byte_a: assert property (
      @(posedge link_clk) disable iff (!link_nrst)
      rsp_valid |-> rsp_data[sleep_status_pkg::ZERO_FIELD_HI:
         sleep_status_pkg::ZERO_FIELD_LO] == 5'h00)
      else $error("reserved answer bits set");

   enter_sleep_c: cover property (
      state == sleep_status_pkg::ST_ENTERING ##1
      state == sleep_status_pkg::ST_ASLEEP);
   wake_c: cover property (
      state == sleep_status_pkg::ST_WAKING ##1
      state == sleep_status_pkg::ST_AWAKE);
   read_diag_c: cover property (
      new_cmd && cmd_hold == sleep_status_pkg::CMD_READ_SELF_DIAG);

endmodule

`default_nettype wire

// file: verif/host_link_model.sv
// Host model that issues one-byte commands over the link
`timescale 1ns/1ns
`default_nettype none

module host_link_model
(
   // Link side
   input wire logic link_clk,
   output logic cmd_valid,
   output logic [7:0] cmd_code,
   input wire logic rsp_valid,
   input wire logic [7:0] rsp_data,
   input wire logic link_busy
);
   initial
   begin
      cmd_valid = 1'b0;
      cmd_code = 8'h00;
   end

   // -------------------------------------------------------------
   // Command transfer
   // -------------------------------------------------------------
   // One command at a time; the next one waits until busy has fallen
   task automatic send_cmd(input logic [7:0] code, output logic [7:0] data,
      output logic got, output logic done);
      int n;
      begin
         @(posedge link_clk);
         cmd_valid <= 1'b1;
         cmd_code <= code;
         @(posedge link_clk);
         while (link_busy !== 1'b0)
            @(posedge link_clk);
         cmd_valid <= 1'b0;
         // Released code lines show no stale value
         cmd_code <= ~code;
         for (n = 0; n < 40; n++)
         begin
            @(posedge link_clk);
            #1;
            if (link_busy === 1'b0)
               break;
         end
         done = (link_busy === 1'b0);
         got = (rsp_valid === 1'b1);
         data = rsp_data;
      end
   endtask
endmodule

`default_nettype wire

// file: verif/display_sleep_and_status_commands_tb_top.sv
// Testbench for the sleep and status command block
`timescale 1ns/1ns
`default_nettype none

module display_sleep_and_status_commands_tb_top;
   // Short settle so the run stays small; 5 ms scales to this
   localparam int SETTLE = 20;
   logic sys_clk;
   logic nrst;
   logic soft_reset;
   logic link_clk;
   logic link_nrst;
   logic cmd_valid;
   logic [7:0] cmd_code;
   logic rsp_valid;
   logic [7:0] rsp_data;
   logic link_busy;
   sleep_status_pkg::signal_status_type sig_status;
   sleep_status_pkg::diag_check_type diag_check;
   logic als_request;
   logic dimming_request;
   sleep_status_pkg::power_ctl_type power_ctl;
   logic asleep;
   int mismatches;
   int check_count;

   sleep_status_ctl #(.SETTLE_CYCLES(SETTLE)) u_dut (
      .sys_clk(sys_clk), .nrst(nrst), .soft_reset(soft_reset),
      .link_clk(link_clk), .link_nrst(link_nrst), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .link_busy(link_busy), .sig_status(sig_status),
      .diag_check(diag_check), .als_request(als_request),
      .dimming_request(dimming_request), .power_ctl(power_ctl),
      .asleep(asleep)
   );

   host_link_model u_host (
      .link_clk(link_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .link_busy(link_busy)
   );

   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   initial
   begin
      link_clk = 1'b0;
      #7;
      forever #16 link_clk = ~link_clk;
   end

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   task automatic check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic sys_wait(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic cmd(input logic [7:0] code, input logic ans,
      input logic [7:0] exp);
      logic [7:0] d;
      logic got;
      logic done;
      u_host.send_cmd(code, d, got, done);
      check("busy released", {7'h00, done}, 8'h01);
      check("answer pulse", {7'h00, got}, {7'h00, ans});
      if (ans)
         check("answer byte", d, exp);
   endtask

   task automatic wait_asleep(input logic v, input int lim);
      int n;
      for (n = 0; n < lim; n++)
      begin
         if (asleep === v)
            break;
         sys_wait(1);
      end
      check("asleep", {7'h00, asleep}, {7'h00, v});
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      #500000;
      mismatches++;
      $display("watchdog expired");
      tally_and_finish();
   end

   // -------------------------------------------------------------
   // Tests
   // -------------------------------------------------------------
   initial
   begin
      mismatches = 0;
      check_count = 0;
      nrst = 1'b0;
      link_nrst = 1'b0;
      soft_reset = 1'b0;
      sig_status = 3'b000;
      diag_check = 3'b000;
      als_request = 1'b1;
      dimming_request = 1'b1;
      repeat (12) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge link_clk);
      link_nrst <= 1'b1;
      sys_wait(4);
      check("asleep", {7'h00, asleep}, 8'h01);
      check("power", {1'b0, power_ctl}, 8'h00);
      cmd(sleep_status_pkg::CMD_READ_SELF_DIAG, 1'b1, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 8; i++)
      begin
         @(posedge sys_clk);
         sig_status <= i[2:0];
         sys_wait(2);
         cmd(8'h0E, 1'b1, {i[2], i[1], 5'h00, i[0]});
      end
      $display("test signal status done");
      cmd(sleep_status_pkg::CMD_SLEEP_ENTRY, 1'b0, 8'h00);
      sys_wait(SETTLE + 5);
      cmd(8'h3C, 1'b0, 8'h00);
      sys_wait(2 * SETTLE);
      check("asleep", {7'h00, asleep}, 8'h01);
      check("power", {1'b0, power_ctl}, 8'h00);
      $display("test stay asleep done");
      @(posedge sys_clk);
      diag_check <= 3'b111;
      cmd(sleep_status_pkg::CMD_SLEEP_EXIT, 1'b0, 8'h00);
      wait_asleep(1'b0, 20);
      sys_wait(SETTLE + 5);
      check("power", {1'b0, power_ctl}, 8'h7F);
      cmd(sleep_status_pkg::CMD_READ_SELF_DIAG, 1'b1, 8'hC1);
      sys_wait(SETTLE + 5);
      cmd(sleep_status_pkg::CMD_SLEEP_ENTRY, 1'b0, 8'h00);
      check("power", {1'b0, power_ctl}, 8'h60);
      wait_asleep(1'b1, SETTLE + 10);
      check("power", {1'b0, power_ctl}, 8'h00);
      sys_wait(SETTLE + 5);
      $display("test wake and sleep done");
      @(posedge sys_clk);
      diag_check <= 3'b100;
      cmd(sleep_status_pkg::CMD_SLEEP_EXIT, 1'b0, 8'h00);
      wait_asleep(1'b0, 20);
      sys_wait(SETTLE + 5);
      cmd(sleep_status_pkg::CMD_READ_SELF_DIAG, 1'b1, 8'h40);
      $display("test second wake done");
      @(posedge sys_clk);
      soft_reset <= 1'b1;
      sys_wait(3);
      @(posedge sys_clk);
      soft_reset <= 1'b0;
      sys_wait(2);
      check("asleep", {7'h00, asleep}, 8'h01);
      check("power", {1'b0, power_ctl}, 8'h00);
      cmd(sleep_status_pkg::CMD_READ_SELF_DIAG, 1'b1, 8'h00);
      $display("test soft reset done");
      tally_and_finish();
   end
endmodule

`default_nettype wire
